// ==== core/udse_core.v ====
// device status, remote wakeup and endpoint interrupt aggregation for a usb device core
// assumes a classic wishbone master on clk_i and per-endpoint cause flags from the core
//
// What this block does
// - while wakeup bit is set in suspend, drive remote wakeup signalling to host
// - status bits 21:8 show last received sof frame number, reset zero
// - erratic phy error sets bit 3, suspends, and raises early suspend flag
// - speed field 2:1 reports chirp result: 2 low, 3 full; resets to 1
// - suspend bit 0 is one while suspend seen; long idle enters suspend
// - suspend ends on bus activity or software writing the wakeup bit
// - both common masks reset fully masked; causes count only when unmasked
// - in mask: nak 13, underrun 8, nak effective 6, token fifo empty 4
// - in mask bit 3 unmasks timeout, non-isochronous endpoints only
// - both masks: bus error 2, endpoint disabled 1, transfer done 0
// - out mask: nak 13, babble 12, out packet error 8
// - out mask bit 6 gates back-to-back setup, control out endpoints only
// - out mask bit 4 gates out token while disabled, control out only
// - out mask bit 3 gates setup phase done, control endpoints only
// - endpoint events reach software via out or in summary core bits
// - summary holds one bit per endpoint per direction
// - summary bits are read only and follow per-endpoint flags
// - out summary bits 22..17 for endpoints 6..1, reset zero
// - out endpoint 0 summary at bit 16
// - in summary bits 0..6 for endpoints 0..6
`timescale 1ns/1ps
`include "udse_regs.vh"

module udse_core #(
  parameter NUM_EP = 7                           // endpoints per direction
) (
  input  wire                clk_i,              // core clock, 200 MHz
  input  wire                rst_i,              // synchronous reset, active high
  input  wire [31:0]         wb_adr_i,           // wishbone byte address
  input  wire [31:0]         wb_dat_i,           // wishbone write data
  input  wire [3:0]          wb_sel_i,           // wishbone byte selects
  input  wire                wb_we_i,            // wishbone write enable
  input  wire                wb_cyc_i,           // wishbone cycle
  input  wire                wb_stb_i,           // wishbone strobe
  output reg  [31:0]         wb_dat_o,           // wishbone read data
  output reg                 wb_ack_o,           // wishbone acknowledge
  output reg                 wb_err_o,           // unmapped address answer
  input  wire                sof_valid_i,        // pulse: sof packet received
  input  wire [13:0]         sof_frame_i,        // frame number of that sof
  input  wire                speed_valid_i,      // pulse: chirp sequence finished
  input  wire [1:0]          speed_i,            // negotiated speed code
  input  wire                erratic_i,          // pin-level erratic phy error
  input  wire                bus_idle_i,         // pin-level long idle seen on bus
  input  wire                bus_activity_i,     // pin-level bus activity
  input  wire [32*NUM_EP-1:0] in_flags_i,        // per in endpoint cause flags
  input  wire [32*NUM_EP-1:0] out_flags_i,       // per out endpoint cause flags
  output reg                 remote_wakeup_o,    // drive resume signalling on bus
  output reg                 early_suspend_o,    // early suspend flag to core irq reg
  output reg                 in_endpoints_summary_o,  // core in endpoints bit
  output reg                 out_endpoints_summary_o, // core out endpoints bit
  output reg  [NUM_EP-1:0]   in_ep_request_o,    // masked per in endpoint request
  output reg  [NUM_EP-1:0]   out_ep_request_o    // masked per out endpoint request
);

  // synchronisers for pin-level inputs
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  wire      erratic_s  = sync2_reg[0];
  wire      idle_s     = sync2_reg[1];
  wire      activity_s = sync2_reg[2];

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {bus_activity_i, bus_idle_i, erratic_i};
      sync2_reg <= sync1_reg;
    end
  end

  // registers
  reg [13:0] sof_reg;
  reg [1:0]  speed_reg;
  reg        erratic_reg;
  reg        suspend_reg;
  reg        wakeup_reg;
  reg [31:0] in_mask_reg;
  reg [31:0] out_mask_reg;

  // bus decode; one-cycle ack, low address bits select the register
  wire [`UDSE_ADDR_W-1:0] addr = wb_adr_i[`UDSE_ADDR_W-1:0];
  wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire hit_stat = (addr == `UDSE_OFF_DEV_STATUS);
  wire hit_in   = (addr == `UDSE_OFF_IN_MASK);
  wire hit_out  = (addr == `UDSE_OFF_OUT_MASK);
  wire hit_sum  = (addr == `UDSE_OFF_EP_SUMMARY);
  wire hit_ctl  = (addr == `UDSE_OFF_DEV_CONTROL);
  wire mapped   = hit_stat | hit_in | hit_out | hit_sum | hit_ctl;
  wire wr       = req & wb_we_i & mapped;

  // byte lane expansion of select
  wire [31:0] lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire ctl_wr_wake = wr & hit_ctl & wb_sel_i[0];
  // value the wakeup bit takes at this edge; the same write also ends suspend,
  // so the signalling decision must see the new bit against the old suspend state
  wire wakeup_next = ctl_wr_wake ? wb_dat_i[`UDSE_WAKEUP_BIT] : wakeup_reg;

  // per endpoint masked requests
  wire [NUM_EP-1:0] in_req;
  wire [NUM_EP-1:0] out_req;
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g = g + 1) begin : g_ep
      // mask read as zero in reserved positions so stray causes never count
      assign in_req[g]  = |(in_flags_i[32*g+31:32*g] & in_mask_reg);
      assign out_req[g] = |(out_flags_i[32*g+31:32*g] & out_mask_reg);
    end
  endgenerate

  // summary: one bit per endpoint per direction, any flag set; read only
  wire [NUM_EP-1:0] in_any;
  wire [NUM_EP-1:0] out_any;
  generate
    for (g = 0; g < NUM_EP; g = g + 1) begin : g_sum
      assign in_any[g]  = |in_flags_i[32*g+31:32*g];
      assign out_any[g] = |out_flags_i[32*g+31:32*g];
    end
  endgenerate

  reg [31:0] summary;
  always @* begin
    summary = 32'h00000000;
    summary[`UDSE_IN_SUM_LO +: NUM_EP]  = in_any;
    summary[`UDSE_OUT_SUM_LO +: NUM_EP] = out_any;
  end

  // status register image
  reg [31:0] status;
  always @* begin
    status = 32'h00000000;
    status[`UDSE_SOF_HI:`UDSE_SOF_LO]     = sof_reg;
    status[`UDSE_ERRATIC_BIT]             = erratic_reg;
    status[`UDSE_SPEED_HI:`UDSE_SPEED_LO] = speed_reg;
    status[`UDSE_SUSPEND_BIT]             = suspend_reg;
  end

  // read mux
  reg [31:0] rdata;
  always @* begin
    rdata = 32'h00000000;
    if (hit_stat)
      rdata = status;
    if (hit_in)
      rdata = in_mask_reg;
    if (hit_out)
      rdata = out_mask_reg;
    if (hit_sum)
      rdata = summary;
    if (hit_ctl)
      rdata[`UDSE_WAKEUP_BIT] = wakeup_reg;
  end

  // bus answer: ack one cycle after the request, err for unmapped addresses
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
      wb_dat_o <= (req & mapped & ~wb_we_i) ? rdata : 32'h00000000;
    end
  end

  // common masks; reserved bits never store, so they read as zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      in_mask_reg  <= `UDSE_MASK_RESET;
      out_mask_reg <= `UDSE_MASK_RESET;
    end else begin
      if (wr & hit_in)
        in_mask_reg <= ((wb_dat_i & lane) | (in_mask_reg & ~lane)) & `UDSE_IN_MASK_BITS;
      if (wr & hit_out)
        out_mask_reg <= ((wb_dat_i & lane) | (out_mask_reg & ~lane)) & `UDSE_OUT_MASK_BITS;
    end
  end

  // sof frame number and enumerated speed capture
  always @(posedge clk_i) begin
    if (rst_i) begin
      sof_reg   <= `UDSE_SOF_RESET;
      speed_reg <= `UDSE_SPEED_RESET;
    end else begin
      if (sof_valid_i)
        sof_reg <= sof_frame_i;
      // only the documented speed codes are taken from the chirp result
      if (speed_valid_i && (speed_i == `UDSE_SPEED_LOW || speed_i == `UDSE_SPEED_FULL))
        speed_reg <= speed_i;
    end
  end

  // remote wakeup control bit, software owned
  always @(posedge clk_i) begin
    if (rst_i)
      wakeup_reg <= 1'b0;
    else if (ctl_wr_wake)
      wakeup_reg <= wb_dat_i[`UDSE_WAKEUP_BIT];
  end

  // suspend and erratic state; erratic stays until reset since only a
  // soft disconnect, handled outside this block, recovers from it
  always @(posedge clk_i) begin
    if (rst_i) begin
      erratic_reg <= 1'b0;
      suspend_reg <= 1'b0;
    end else begin
      if (erratic_s)
        erratic_reg <= 1'b1;
      // entry wins over exit so an erratic event is never lost
      if (erratic_s | idle_s)
        suspend_reg <= 1'b1;
      else if (activity_s | ctl_wr_wake)
        suspend_reg <= 1'b0;
    end
  end

  // registered outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      remote_wakeup_o         <= 1'b0;
      early_suspend_o         <= 1'b0;
      in_endpoints_summary_o  <= 1'b0;
      out_endpoints_summary_o <= 1'b0;
      in_ep_request_o         <= {NUM_EP{1'b0}};
      out_ep_request_o        <= {NUM_EP{1'b0}};
    end else begin
      // signalling held while bit set and device was suspended when it rose
      remote_wakeup_o         <= wakeup_next & (suspend_reg | remote_wakeup_o);
      early_suspend_o         <= erratic_s;
      in_endpoints_summary_o  <= |in_req;
      out_endpoints_summary_o <= |out_req;
      in_ep_request_o         <= in_req;
      out_ep_request_o        <= out_req;
    end
  end

endmodule

// ==== core/udse_regs.vh ====
// register map and field constants for the device status and endpoint interrupt block
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef UDSE_REGS_VH
`define UDSE_REGS_VH

// register byte offsets, low address bits decoded
`define UDSE_ADDR_W          18
`define UDSE_OFF_DEV_STATUS  18'h3C808
`define UDSE_OFF_IN_MASK     18'h3C810
`define UDSE_OFF_OUT_MASK    18'h3C814
`define UDSE_OFF_EP_SUMMARY  18'h3C818
`define UDSE_OFF_DEV_CONTROL 18'h3C804

// device status fields
`define UDSE_SOF_HI          21
`define UDSE_SOF_LO          8
`define UDSE_ERRATIC_BIT     3
`define UDSE_SPEED_HI        2
`define UDSE_SPEED_LO        1
`define UDSE_SUSPEND_BIT     0
`define UDSE_SPEED_RESET     2'h1
`define UDSE_SPEED_LOW       2'h2
`define UDSE_SPEED_FULL      2'h3
`define UDSE_SOF_RESET       14'h0000

// device control fields held here
`define UDSE_WAKEUP_BIT      0

// common mask layout; only these bits are writable
`define UDSE_IN_MASK_BITS    32'h0000215F
`define UDSE_OUT_MASK_BITS   32'h0000315F
`define UDSE_MASK_RESET      32'h00000000

// summary layout
`define UDSE_OUT_SUM_LO      16
`define UDSE_IN_SUM_LO       0

`endif

// ==== testbench/udse_monitor.sv ====
// assertions on the ports of the status and endpoint interrupt block
// assumes one clock and a master that holds each request until answered
`timescale 1ns/1ps
`include "udse_regs.vh"
module udse_monitor #(parameter NUM_EP = 7) (
  input wire                 clk_i,
  input wire                 rst_i,
  input wire [31:0]          wb_adr_i,
  input wire                 wb_cyc_i,
  input wire                 wb_stb_i,
  input wire [31:0]          wb_dat_o,
  input wire                 wb_ack_o,
  input wire                 wb_err_o,
  input wire                 erratic_i,
  input wire                 early_suspend_o,
  input wire                 remote_wakeup_o,
  input wire [NUM_EP-1:0]    in_ep_request_o,
  input wire [32*NUM_EP-1:0] in_flags_i,
  input wire [32*NUM_EP-1:0] out_flags_i
);
  // a request counts only while no answer is out
  wire        tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire [17:0] a = wb_adr_i[17:0];
  wire        hit = a == `UDSE_OFF_DEV_STATUS || a == `UDSE_OFF_IN_MASK ||
    a == `UDSE_OFF_OUT_MASK || a == `UDSE_OFF_EP_SUMMARY || a == `UDSE_OFF_DEV_CONTROL;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // two synchroniser flops plus the output register
  sequence s_erratic; erratic_i [*4]; endsequence
  sequence s_quiet; (in_flags_i == 0 && out_flags_i == 0) [*3]; endsequence
  a_ack_mapped: assert property (tk && hit |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked");
  a_err_unmapped: assert property (tk && !hit |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_answer_once: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
    else $error("answer too long");
  a_answer_single: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack with err");
  a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  a_erratic_flag: assert property (s_erratic |-> early_suspend_o)
    else $error("no early suspend");
  a_request_idle: assert property (s_quiet |-> in_ep_request_o == 0)
    else $error("request without flag");
  a_wakeup_cause: assert property ($rose(remote_wakeup_o) |->
    wb_ack_o) else $error("wakeup without write");
endmodule
bind udse_core udse_monitor #(.NUM_EP(NUM_EP)) i_mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .erratic_i(erratic_i),
  .early_suspend_o(early_suspend_o), .remote_wakeup_o(remote_wakeup_o),
  .in_ep_request_o(in_ep_request_o), .in_flags_i(in_flags_i), .out_flags_i(out_flags_i));

// ==== testbench/udse_host_model.sv ====
// usb host side model: sof packets, chirp result and bus line levels
// assumes its tasks are called from the clk_i domain
`timescale 1ns/1ps
module udse_host_model (
  input  wire        clk_i,         // core clock
  output reg         sof_o = 1'b0,  // sof strobe
  output reg  [13:0] frame_o = 0,   // frame number
  output reg         spd_v_o = 1'b0, // chirp done strobe
  output reg  [1:0]  spd_o = 0,     // chirp result
  output reg  [2:0]  line_o = 0     // idle, activity, erratic levels
);
  // stale numbers are inverted so they never look valid
  task send_sof(input [13:0] f);
    @(posedge clk_i);
    sof_o <= 1'b1;
    frame_o <= f;
    @(posedge clk_i);
    sof_o <= 1'b0;
    frame_o <= ~f;
  endtask
  task chirp(input [1:0] s);
    @(posedge clk_i);
    spd_v_o <= 1'b1;
    spd_o <= s;
    @(posedge clk_i);
    spd_v_o <= 1'b0;
    spd_o <= ~s;
  endtask
  task set_line(input int k, input v);
    @(posedge clk_i);
    line_o[k] <= v;
  endtask
endmodule

// ==== testbench/tb_udse_core.sv ====
// self-checking bench for the status and endpoint interrupt block
// assumes the host model on the usb side and a 200 MHz clock
`timescale 1ns/1ps
`include "udse_regs.vh"
module tb_udse_core;
  reg          clk_i = 1'b0;
  reg          rst_i = 1'b1;
  reg          req = 1'b0;
  reg          we = 1'b0;
  reg  [31:0]  adr = 32'h0;
  reg  [31:0]  wd = 32'h0;
  reg  [223:0] in_f = 0;
  reg  [223:0] out_f = 0;
  reg  [31:0]  q;
  reg          e;
  wire [31:0]  rd;
  wire [13:0]  fr;
  wire [1:0]   sp;
  wire [2:0]   ln;
  wire [6:0]   ir, orq;
  wire         ack, err, sv, spv, wake, es, isum, osum;
  int          miscompares = 0;
  int          n_compared = 0;
  localparam [17:0] st = `UDSE_OFF_DEV_STATUS, im = `UDSE_OFF_IN_MASK;
  localparam [17:0] om = `UDSE_OFF_OUT_MASK, su = `UDSE_OFF_EP_SUMMARY;
  localparam [31:0] al = 32'hFFFFFFFF;
  udse_host_model i_host (.clk_i(clk_i), .sof_o(sv), .frame_o(fr), .spd_v_o(spv),
    .spd_o(sp), .line_o(ln));
  udse_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(req), .wb_stb_i(req), .wb_dat_o(rd),
    .wb_ack_o(ack), .wb_err_o(err), .sof_valid_i(sv), .sof_frame_i(fr),
    .speed_valid_i(spv), .speed_i(sp), .erratic_i(ln[2]), .bus_idle_i(ln[0]),
    .bus_activity_i(ln[1]), .in_flags_i(in_f), .out_flags_i(out_f),
    .remote_wakeup_o(wake), .early_suspend_o(es), .in_endpoints_summary_o(isum),
    .out_endpoints_summary_o(osum), .in_ep_request_o(ir), .out_ep_request_o(orq));
  task chk(input string what, input [31:0] x, input [31:0] g);
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, x, g);
    end
  endtask
  // held until the edge where the answer is sampled, released there
  task bus(input w, input [17:0] a, input [31:0] d);
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= {14'h0, a};
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    q = rd;
    e = err;
    req <= 1'b0;
    we <= 1'b0;
  endtask
  task rchk(input string what, input [17:0] a, input [31:0] m, input [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(what, x, q & m);
  endtask
  task settle;
    repeat (4) @(posedge clk_i);
  endtask
  task t_regs;
    rchk("status", st, al, 32'h2);
    rchk("in mask", im, al, 0);
    rchk("summary", su, al, 0);
    bus(1'b1, im, al);
    rchk("in mask", im, al, 32'h215F);
    bus(1'b1, om, al);
    rchk("out mask", om, al, 32'h315F);
    bus(1'b0, 18'h3C80C, 0);
    chk("unmapped", 1, {31'h0, e});
  endtask
  // every cause bit, then every endpoint, then masking the in causes off again
  task t_causes;
    for (int b = 0; b < 32; b++) begin
      in_f <= 224'h1 << b;
      out_f <= 224'h1 << b;
      settle;
      chk("in req", (32'h215F >> b) & 1, {25'h0, ir});
      chk("out req", (32'h315F >> b) & 1, {25'h0, orq});
    end
    for (int n = 0; n < 7; n++) begin
      in_f <= 224'h4 << (32 * n);
      out_f <= 224'h100 << (32 * n);
      settle;
      chk("requests", {7'h1 << n, 7'h1 << n}, {ir, orq});
      chk("core bits", 3, {30'h0, isum, osum});
      rchk("summary", su, al, (32'h1 << n) | (32'h10000 << n));
    end
    bus(1'b1, im, 0);
    settle;
    chk("in req masked", 0, {24'h0, ir, isum});
    rchk("summary", su, al, 32'h400040);
  endtask
  task t_frame;
    i_host.chirp(2'h2);
    rchk("speed", st, 6, 4);
    i_host.chirp(2'h3);
    i_host.send_sof(14'h3FFF);
    rchk("frame", st, 32'h3FFF06, 32'h3FFF06);
  endtask
  task t_suspend;
    i_host.set_line(0, 1);
    settle;
    i_host.set_line(0, 0);
    rchk("suspend", st, 1, 1);
    bus(1'b1, `UDSE_OFF_DEV_CONTROL, 1);
    settle;
    chk("wakeup", 1, {31'h0, wake});
    rchk("suspend", st, 1, 0);
    bus(1'b1, `UDSE_OFF_DEV_CONTROL, 0);
    i_host.set_line(0, 1);
    settle;
    i_host.set_line(0, 0);
    i_host.set_line(1, 1);
    settle;
    i_host.set_line(1, 0);
    rchk("resume", st, 1, 0);
    i_host.set_line(2, 1);
    settle;
    chk("early suspend", 1, {31'h0, es});
    rchk("erratic", st, 9, 9);
  endtask
  task final_report;
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_causes;
    t_frame;
    t_suspend;
    final_report;
  end
  // a hung handshake ends the run as a failure
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    final_report;
  end
endmodule
